/* core/gptp_defs.svh */
// gptp_defs.svh: register offsets, field positions, reset values, timing counts
// assumes a 32-bit AHB-Lite slave with word-aligned registers
// What this block does
// R1 - two half-width counters run alone or join as one full-width timer
// R2 - a wide build pairs two 32-bit halves into one 64-bit timer
// R3 - one-shot mode stops counting when the count reaches its end
// R4 - periodic mode reloads the count at its end and keeps counting
// R5 - rtc mode only at full width, counts 32 KHz divided to seconds
// R6 - half-width capture counts edges or measures time between edges
// R7 - capture event selectable as rising, falling or both edges
// R8 - half-width pwm mode turns the capture pin into an edge-aligned output
// R9 - timer and capture modes may count up instead of down
// R10 - software disables before reconfiguring; configuring leaves timers disabled
// R11 - full mode is one-shot, periodic, rtc or split pair of half modes
// R12 - interrupts on capture, count match, timeout and rtc match
// R13 - each half has output inversion, trigger output and stall settings
// R14 - with stall set, counting freezes while the processor is debug-halted
// R15 - wait-on-trigger holds a timer until the preceding timer times out
// R16 - an interrupt source reaches the output only while enabled
// R17 - joined halves count as one value, first half low, second half high
`ifndef GPTP_DEFS_SVH
`define GPTP_DEFS_SVH

// ********************************
// register byte offsets
// ********************************
`define GPTP_CFG 8'h00
`define GPTP_MODE_A 8'h04
`define GPTP_MODE_B 8'h08
`define GPTP_CTL 8'h0c
`define GPTP_LOAD_A 8'h10
`define GPTP_LOAD_B 8'h14
`define GPTP_MATCH_A 8'h18
`define GPTP_MATCH_B 8'h1c
`define GPTP_VAL_A 8'h20
`define GPTP_VAL_B 8'h24
`define GPTP_CAP_A 8'h28
`define GPTP_CAP_B 8'h2c
`define GPTP_RIS 8'h30
`define GPTP_ICLR 8'h34
`define GPTP_IEN 8'h38

// ********************************
// field positions
// ********************************
`define GPTP_CFG_UP 2
`define GPTP_MD_UP 3
`define GPTP_MD_EDGE 4
`define GPTP_MD_INV 6
`define GPTP_MD_TRG 7
`define GPTP_MD_STL 8
`define GPTP_MD_WOT 9
`define GPTP_INT_TO 0
`define GPTP_INT_CM 1
`define GPTP_INT_CE 2
`define GPTP_INT_RTC 3
`define GPTP_INT_B 4

// ********************************
// reset values and timing
// ********************************
`define GPTP_RST_LOAD 32'hffff_ffff
`define GPTP_RST_MD 10'h000
`define GPTP_RTC_DIV 32768

`endif

/* core/gptp_half.sv */
// gptp_half: one half-width counter with load and up/down step
// assumes the caller decides when to step and when to load
`timescale 1ns/1ps
module gptp_half #(
    parameter int W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic step,
    input wire logic up,
    input wire logic ld,
    input wire logic [W-1:0] ld_val,
    output logic [W-1:0] cnt
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // ********************************
    // counter
    // ********************************
    always_comb begin
        nxt_cnt = cnt_ff;
        if (ld) begin
            nxt_cnt = ld_val;
        end else if (step) begin
            nxt_cnt = up ? cnt_ff + W'(1) : cnt_ff - W'(1); // [R1] [R9]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign cnt = cnt_ff;

    chk_step_down: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        step && !ld && !up |=> cnt_ff == $past(cnt_ff) - W'(1))
        else $error("down step did not decrement");
    chk_step_up: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
        step && !ld && up |=> cnt_ff == $past(cnt_ff) + W'(1))
        else $error("up step did not increment");
endmodule : gptp_half

/* core/gptp_pkg.sv */
// gptp_pkg: mode types of the timer pair
// assumes gptp_defs.svh supplies the numeric constants
package gptp_pkg;
    typedef enum logic [1:0] {
        full_one_shot,
        full_periodic,
        full_rtc,
        full_split_pair
    } gptp_full_t;
    typedef enum logic [2:0] {
        half_one_shot,
        half_periodic,
        half_edge_count_capture,
        half_edge_time_capture,
        half_pwm
    } gptp_half_t;
    typedef enum logic [1:0] {
        edge_rise,
        edge_fall,
        edge_both
    } gptp_edge_t;
endpackage : gptp_pkg

/* core/gptp_top.sv */
// gptp_top: timer pair with AHB-Lite registers, capture/pwm pins, rtc input
// assumes all inputs are synchronous to hclk; rtc_clk_in is a sampled level
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "gptp_defs.svh"
module gptp_top
    import gptp_pkg::*;
#(
    parameter int HW = 16,
    parameter int RTC_DIV = `GPTP_RTC_DIV
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic dbg_halt,
    input wire logic trig_in,
    input wire logic rtc_clk_in,
    input wire logic [1:0] cap_in,
    output logic [1:0] pwm_out,
    output logic [1:0] pwm_oe,
    output logic [1:0] trig_out,
    output logic irq
);
    localparam int DW = $clog2(RTC_DIV);

    logic ap_ff, nxt_ap, wr_ff, nxt_wr, wsel;
    logic [7:0] adr_ff, nxt_adr;
    logic [31:0] rd_ff, nxt_rd;
    gptp_full_t cfg_ff, nxt_cfg;
    logic fup_ff, nxt_fup;
    logic [9:0] md_ff [2];
    logic [9:0] nxt_md [2];
    logic [1:0] en_ff, nxt_en;
    logic [HW-1:0] ld_ff [2];
    logic [HW-1:0] nxt_ld [2];
    logic [HW-1:0] mt_ff [2];
    logic [HW-1:0] nxt_mt [2];
    logic [7:0] ien_ff, nxt_ien, ris_ff, nxt_ris, set, clr;
    logic [HW-1:0] cap_ff [2];
    logic [HW-1:0] nxt_cap [2];
    logic [HW-1:0] cnt [2];
    logic [HW-1:0] ldv [2];
    logic [HW-1:0] nv;
    logic [1:0] wait_ff, nxt_wait, pin_q_ff, pwm_ff, nxt_pwm, oe_ff, nxt_oe;
    logic [1:0] trg_ff, nxt_trg;
    logic rtc_q_ff, irq_ff, nxt_irq;
    logic [DW-1:0] div_ff, nxt_div;
    gptp_half_t hm [2];
    logic [1:0] up, ev, act, hterm, start, step, ld, to, cm, ce, clr_en, prev;
    logic full, rtc_rise, sec_tick, carry, fterm, rtcm;

    // ********************************
    // bus slave
    // ********************************
    // zero wait states: read data is registered in the address phase
    always_comb begin
        nxt_ap = hsel & htrans[1] & hready;
        nxt_wr = hwrite;
        nxt_adr = haddr[7:0];
        nxt_rd = '0;
        if (nxt_ap && !hwrite) begin
            case (haddr[7:0])
                `GPTP_CFG: nxt_rd = 32'({fup_ff, cfg_ff});
                `GPTP_MODE_A: nxt_rd = 32'(md_ff[0]);
                `GPTP_MODE_B: nxt_rd = 32'(md_ff[1]);
                `GPTP_CTL: nxt_rd = 32'(en_ff);
                `GPTP_LOAD_A: nxt_rd = 32'(ld_ff[0]);
                `GPTP_LOAD_B: nxt_rd = 32'(ld_ff[1]);
                `GPTP_MATCH_A: nxt_rd = 32'(mt_ff[0]);
                `GPTP_MATCH_B: nxt_rd = 32'(mt_ff[1]);
                `GPTP_VAL_A: nxt_rd = 32'(cnt[0]);
                `GPTP_VAL_B: nxt_rd = 32'(cnt[1]);
                `GPTP_CAP_A: nxt_rd = 32'(cap_ff[0]);
                `GPTP_CAP_B: nxt_rd = 32'(cap_ff[1]);
                `GPTP_RIS: nxt_rd = 32'(ris_ff);
                `GPTP_IEN: nxt_rd = 32'(ien_ff);
                default: nxt_rd = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_ff <= 1'b0;
            wr_ff <= 1'b0;
            adr_ff <= '0;
            rd_ff <= '0;
        end else begin
            ap_ff <= nxt_ap;
            wr_ff <= nxt_wr;
            adr_ff <= nxt_adr;
            rd_ff <= nxt_rd;
        end
    end

    assign wsel = ap_ff & wr_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd_ff;

    // ********************************
    // counting control
    // ********************************
    always_comb begin
        full = cfg_ff != full_split_pair;
        rtc_rise = rtc_clk_in & ~rtc_q_ff;
        sec_tick = rtc_rise && div_ff == DW'(RTC_DIV - 1); // [R5]
        prev[0] = trig_in;
        step = '0;
        to = '0;
        cm = '0;
        ce = '0;
        clr_en = '0;
        rtcm = 1'b0;
        nv = '0;
        for (int h = 0; h < 2; h++) begin
            hm[h] = gptp_half_t'(md_ff[h][2:0]);
            up[h] = full ? (fup_ff || cfg_ff == full_rtc) : md_ff[h][`GPTP_MD_UP]; // [R9]
            act[h] = en_ff[h] & ~wait_ff[h] & ~(dbg_halt & md_ff[h][`GPTP_MD_STL]); // [R14]
            start[h] = wsel && adr_ff == `GPTP_CTL && hwdata[h] && !en_ff[h];
            hterm[h] = up[h] ? cnt[h] == ld_ff[h] : cnt[h] == '0;
            ldv[h] = (up[h] && cfg_ff != full_rtc) ? '0 : ld_ff[h];
            // full width: one enable loads both halves
            ld[h] = start[h] | (full & start[0]); // [R11] [R17]
            case (gptp_edge_t'(md_ff[h][`GPTP_MD_EDGE +: 2])) // [R7]
                edge_rise: ev[h] = cap_in[h] & ~pin_q_ff[h];
                edge_fall: ev[h] = ~cap_in[h] & pin_q_ff[h];
                default: ev[h] = cap_in[h] ^ pin_q_ff[h];
            endcase
        end
        fterm = hterm[0] & hterm[1];
        carry = up[0] ? &cnt[0] : cnt[0] == '0; // [R17]
        if (full) begin
            // the second half follows the first half's enable and stall
            if (act[0] && (cfg_ff != full_rtc || sec_tick)) begin // [R11]
                if (cfg_ff == full_rtc) begin
                    rtcm = {cnt[1], cnt[0]} == {mt_ff[1], mt_ff[0]}; // [R5] [R12]
                    step = {carry, 1'b1};
                end else if (fterm) begin
                    to[0] = 1'b1; // [R12]
                    if (cfg_ff == full_periodic) begin
                        ld = 2'b11; // [R4]
                    end else begin
                        clr_en[0] = 1'b1; // [R3]
                    end
                end else begin
                    step = {carry, 1'b1}; // [R1] [R2] [R17]
                end
            end
        end else begin
            for (int h = 0; h < 2; h++) begin
                nv = up[h] ? cnt[h] + HW'(1) : cnt[h] - HW'(1);
                if (hm[h] == half_edge_count_capture) begin // [R6]
                    if (act[h] && ev[h]) begin
                        step[h] = 1'b1;
                        if (nv == mt_ff[h]) begin
                            cm[h] = 1'b1; // [R12]
                            clr_en[h] = 1'b1;
                        end
                    end
                end else if (act[h]) begin
                    if (!hterm[h]) begin
                        step[h] = 1'b1;
                    end else begin
                        to[h] = 1'b1; // [R12]
                        if (hm[h] == half_one_shot) begin
                            clr_en[h] = 1'b1; // [R3]
                        end else begin
                            ld[h] = 1'b1; // [R4]
                        end
                    end
                end
                if ((hm[h] == half_edge_time_capture || hm[h] == half_edge_count_capture) && en_ff[h] && ev[h]) begin
                    ce[h] = 1'b1; // [R6] [R12]
                end
            end
        end
        prev[1] = to[0];
    end

    gptp_half #(
        .W(HW)
    ) first_half_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .step(step[0]),
        .up(up[0]),
        .ld(ld[0]),
        .ld_val(ldv[0]),
        .cnt(cnt[0])
    );

    gptp_half #(
        .W(HW)
    ) second_half_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .step(step[1]),
        .up(up[1]),
        .ld(ld[1]),
        .ld_val(ldv[1]),
        .cnt(cnt[1])
    );

    // ********************************
    // configuration registers
    // ********************************
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_fup = fup_ff;
        nxt_md = md_ff;
        nxt_en = en_ff & ~clr_en;
        nxt_ld = ld_ff;
        nxt_mt = mt_ff;
        nxt_ien = ien_ff;
        if (wsel) begin
            case (adr_ff)
                `GPTP_CFG: begin
                    nxt_cfg = gptp_full_t'(hwdata[1:0]); // [R11]
                    nxt_fup = hwdata[`GPTP_CFG_UP];
                    nxt_en = '0; // [R10]
                end
                `GPTP_MODE_A: begin
                    nxt_md[0] = hwdata[9:0]; // [R13]
                    nxt_en[0] = 1'b0; // [R10]
                end
                `GPTP_MODE_B: begin
                    nxt_md[1] = hwdata[9:0];
                    nxt_en[1] = 1'b0; // [R10]
                end
                `GPTP_CTL: nxt_en = hwdata[1:0];
                `GPTP_LOAD_A: nxt_ld[0] = hwdata[HW-1:0];
                `GPTP_LOAD_B: nxt_ld[1] = hwdata[HW-1:0];
                `GPTP_MATCH_A: nxt_mt[0] = hwdata[HW-1:0];
                `GPTP_MATCH_B: nxt_mt[1] = hwdata[HW-1:0];
                `GPTP_IEN: nxt_ien = hwdata[7:0];
                default: nxt_ien = ien_ff;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff <= full_one_shot;
            fup_ff <= 1'b0;
            en_ff <= '0;
            ien_ff <= '0;
            for (int h = 0; h < 2; h++) begin
                md_ff[h] <= `GPTP_RST_MD;
                ld_ff[h] <= HW'(`GPTP_RST_LOAD);
                mt_ff[h] <= '0;
            end
        end else begin
            cfg_ff <= nxt_cfg;
            fup_ff <= nxt_fup;
            en_ff <= nxt_en;
            ien_ff <= nxt_ien;
            md_ff <= nxt_md;
            ld_ff <= nxt_ld;
            mt_ff <= nxt_mt;
        end
    end

    // ********************************
    // status, pins and interrupt
    // ********************************
    always_comb begin
        nxt_div = div_ff;
        if (start[0]) begin
            nxt_div = '0;
        end else if (cfg_ff == full_rtc && act[0] && rtc_rise) begin
            nxt_div = sec_tick ? '0 : div_ff + DW'(1); // [R5]
        end
        set = '0;
        for (int h = 0; h < 2; h++) begin
            set[`GPTP_INT_B * h + `GPTP_INT_TO] = to[h]; // [R12]
            set[`GPTP_INT_B * h + `GPTP_INT_CM] = cm[h];
            set[`GPTP_INT_B * h + `GPTP_INT_CE] = ce[h];
            nxt_cap[h] = ce[h] ? cnt[h] : cap_ff[h]; // [R6]
            nxt_wait[h] = start[h] ? md_ff[h][`GPTP_MD_WOT] : wait_ff[h] & ~prev[h]; // [R15]
            nxt_pwm[h] = (cnt[h] > mt_ff[h]) ^ md_ff[h][`GPTP_MD_INV]; // [R8] [R13]
            nxt_oe[h] = !full && hm[h] == half_pwm; // [R8]
            nxt_trg[h] = to[h] & md_ff[h][`GPTP_MD_TRG]; // [R13]
        end
        set[`GPTP_INT_RTC] = rtcm;
        clr = (wsel && adr_ff == `GPTP_ICLR) ? hwdata[7:0] : '0;
        // a new event in the clearing cycle survives the clear
        nxt_ris = (ris_ff & ~clr) | set;
        nxt_irq = |(ris_ff & ien_ff); // [R16]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= '0;
            ris_ff <= '0;
            wait_ff <= '0;
            pin_q_ff <= '0;
            rtc_q_ff <= 1'b0;
            pwm_ff <= '0;
            oe_ff <= '0;
            trg_ff <= '0;
            irq_ff <= 1'b0;
            for (int h = 0; h < 2; h++) begin
                cap_ff[h] <= '0;
            end
        end else begin
            div_ff <= nxt_div;
            ris_ff <= nxt_ris;
            wait_ff <= nxt_wait;
            pin_q_ff <= cap_in;
            rtc_q_ff <= rtc_clk_in;
            pwm_ff <= nxt_pwm;
            oe_ff <= nxt_oe;
            trg_ff <= nxt_trg;
            irq_ff <= nxt_irq;
            cap_ff <= nxt_cap;
        end
    end

    assign pwm_out = pwm_ff;
    assign pwm_oe = oe_ff;
    assign trig_out = trg_ff;
    assign irq = irq_ff;

    // ********************************
    // checks
    // ********************************
    chk_oneshot_stop: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
        !full && hm[0] == half_one_shot && act[0] && hterm[0] && !wsel |=> !en_ff[0] ##1 $stable(cnt[0]))
        else $error("one-shot kept running after its end");
    chk_periodic_reload: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
        !full && hm[0] == half_periodic && act[0] && hterm[0] |=> cnt[0] == $past(ldv[0]) && en_ff[0])
        else $error("periodic half did not reload");
    chk_cfg_disables: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
        wsel && adr_ff == `GPTP_CFG |=> en_ff == 2'b00)
        else $error("configuration left a timer enabled");
    chk_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
        (ris_ff & ien_ff) == '0 ##1 (ris_ff & ien_ff) == '0 |=> !irq_ff)
        else $error("interrupt raised with no enabled source");
    chk_capture_time: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
        !full && hm[0] == half_edge_time_capture && en_ff[0] && ev[0]
        |=> cap_ff[0] == $past(cnt[0]) && ris_ff[`GPTP_INT_CE])
        else $error("edge did not capture the count");
    chk_wait_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
        !full && wait_ff[1] && !wsel |=> $stable(cnt[1]))
        else $error("waiting timer counted before its trigger");
    chk_stall_freeze: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
        !full && dbg_halt && md_ff[0][`GPTP_MD_STL] && !wsel |=> $stable(cnt[0]))
        else $error("stalled timer kept counting");
    chk_full_carry: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
        full && cfg_ff != full_rtc && act[0] && !fterm && !up[0] && cnt[0] == '0
        |=> cnt[1] == $past(cnt[1]) - HW'(1) && cnt[0] == '1)
        else $error("borrow did not reach the high half");
    chk_rtc_second: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
        cfg_ff == full_rtc && act[0] && !sec_tick |=> $stable(cnt[0]))
        else $error("rtc counted without a second tick");
    chk_pwm_drive: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        !full && hm[1] == half_pwm |=> pwm_oe[1])
        else $error("pwm half does not drive its pin");
endmodule : gptp_top

/* verification/general_purpose_timer_pair_tb.sv */
// general_purpose_timer_pair_tb: register-level test of the timer pair
// assumes zero-wait AHB-Lite slave, rtc divider shortened to 4
`timescale 1ns/1ps
`include "gptp_defs.svh"
module general_purpose_timer_pair_tb
    import gptp_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
    logic dbg_halt = 0, trig_in = 0, rtc_clk_in = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, v;
    logic [1:0] htrans = 0, cap_in, pwm_out, pwm_oe, trig_out;
    logic [2:0] hsize = 3'h2;
    int fails = 0, checks_done = 0, trig_seen = 0, ld;
    int seed = 32'h0a01dc94;
    int mdl [16];
    gptp_top #(.HW(16), .RTC_DIV(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dbg_halt(dbg_halt), .trig_in(trig_in),
        .rtc_clk_in(rtc_clk_in), .cap_in(cap_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .trig_out(trig_out), .irq(irq));
    gptp_pin_model PIN (.hclk(hclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .cap_in(cap_in));
    assign hready = hreadyout;
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (trig_out[0] === 1'b1) trig_seen++;
    end
    // ****************
    // bus and check tasks
    // ****************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            if (n++ > 50) begin
                fails++;
                finish_test;
            end
            @(posedge hclk);
        end
    endtask : rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, r);
        mdl[a[5:2]] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd
    // poll a status bit; bounded so a dead timer ends the run
    task automatic wris(input int b);
        int n;
        n = 0;
        r = 0;
        while (r[b] !== 1'b1) begin
            if (n++ > 150) begin
                fails++;
                finish_test;
            end
            xfer(1'b0, `GPTP_RIS, 32'h0, r);
        end
    endtask : wris
    // level outputs looked at mid-cycle, then back on the rising edge
    // sel 0 looks at irq, sel 1 at pwm_oe[1], both read at the falling edge
    task automatic nchk(input int sel, input logic exp);
        @(negedge hclk);
        chk(32'(sel ? pwm_oe[1] : irq), 32'(exp));
        @(posedge hclk);
    endtask : nchk
    initial begin
        #(25 * 60000);
        fails++;
        finish_test;
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        foreach (mdl[i]) mdl[i] = 0;
        mdl[4] = 32'h0000ffff;
        mdl[5] = 32'h0000ffff;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 16; i++) rd(8'(i * 4), 32'(mdl[i]));
        xfer(1'b1, 8'h80, 32'h5a, r);
        rd(8'h80, 32'h0);
        xfer(1'b1, `GPTP_VAL_A, 32'h1234, r);
        rd(`GPTP_VAL_A, 32'h0);
        // one-shot with a random load, then interrupt mask and clear
        ld = 3 + ($random(seed) & 7);
        wr(`GPTP_CFG, 32'(full_split_pair));
        wr(`GPTP_MODE_A, 32'(half_one_shot));
        wr(`GPTP_LOAD_A, 32'(ld));
        rd(`GPTP_LOAD_A, 32'(mdl[4]));
        wr(`GPTP_CTL, 32'h1);
        wris(`GPTP_INT_TO);
        rd(`GPTP_VAL_A, 32'h0);
        rd(`GPTP_CTL, 32'h0);
        nchk(0, 1'b0);
        wr(`GPTP_IEN, 32'h1);
        repeat (3) @(posedge hclk);
        nchk(0, 1'b1);
        wr(`GPTP_ICLR, 32'h1);
        rd(`GPTP_RIS, 32'h0);
        repeat (3) @(posedge hclk);
        nchk(0, 1'b0);
        // periodic keeps running after each timeout
        wr(`GPTP_MODE_B, 32'(half_periodic));
        wr(`GPTP_LOAD_B, 32'h4);
        wr(`GPTP_CTL, 32'h2);
        wris(`GPTP_INT_B);
        wr(`GPTP_ICLR, 32'h10);
        wris(`GPTP_INT_B);
        rd(`GPTP_CTL, 32'h2);
        wr(`GPTP_CTL, 32'h0);
        // every capture mode with every edge choice, counting up
        for (int m = 2; m < 4; m++) begin
            for (int e = 0; e < 3; e++) begin
                wr(`GPTP_MATCH_A, 32'h3);
                wr(`GPTP_MODE_A, 32'(m | 8 | (e << 4)));
                wr(`GPTP_ICLR, 32'h7f);
                wr(`GPTP_CTL, 32'h1);
                PIN.pulse(0, e == 2 ? 2 : 3);
                xfer(1'b0, `GPTP_RIS, 32'h0, r);
                chk(32'(r[2]), 32'h1);
                if (m == 2) chk(32'(r[1]), 32'h1);
            end
        end
        // pwm duty from load 9 and match 6, plain and inverted
        for (int inv = 0; inv < 2; inv++) begin
            wr(`GPTP_MODE_B, 32'(int'(half_pwm) | (inv << 6)));
            wr(`GPTP_LOAD_B, 32'h9);
            wr(`GPTP_MATCH_B, 32'h6);
            wr(`GPTP_CTL, 32'h2);
            repeat (4) @(posedge hclk);
            nchk(1, 1'b1);
            @(negedge hclk);
            PIN.high_cnt = 0;
            repeat (20) @(negedge hclk);
            chk(32'(PIN.high_cnt), inv ? 32'd14 : 32'd6);
            @(posedge hclk);
        end
        // stall freezes only while halted
        wr(`GPTP_MODE_A, 32'h101);
        wr(`GPTP_LOAD_A, 32'hffff);
        wr(`GPTP_CTL, 32'h1);
        dbg_halt <= 1'b1;
        repeat (2) @(posedge hclk);
        xfer(1'b0, `GPTP_VAL_A, 32'h0, v);
        rd(`GPTP_VAL_A, v);
        dbg_halt <= 1'b0;
        repeat (2) @(posedge hclk);
        xfer(1'b0, `GPTP_VAL_A, 32'h0, r);
        chk(32'(r !== v), 32'h1);
        // B waits for A's timeout; A raises its trigger output
        wr(`GPTP_CTL, 32'h0);
        wr(`GPTP_LOAD_A, 32'd20);
        wr(`GPTP_MODE_A, 32'h081);
        wr(`GPTP_MODE_B, 32'h200);
        wr(`GPTP_LOAD_B, 32'h2);
        wr(`GPTP_ICLR, 32'h7f);
        wr(`GPTP_CTL, 32'h3);
        trig_seen = 0;
        repeat (2) @(posedge hclk);
        rd(`GPTP_VAL_B, 32'h2);
        wris(`GPTP_INT_B);
        chk(32'(trig_seen > 0), 32'h1);
        rd(`GPTP_CTL, 32'h1);
        wr(`GPTP_MODE_A, 32'h1);
        rd(`GPTP_CTL, 32'h0);
        // A waits for the trigger input pulse, then counts down from 20
        wr(`GPTP_MODE_A, 32'h201);
        wr(`GPTP_CTL, 32'h1);
        repeat (3) @(posedge hclk);
        rd(`GPTP_VAL_A, 32'd20);
        trig_in <= 1'b1;
        @(posedge hclk);
        trig_in <= 1'b0;
        repeat (3) @(posedge hclk);
        xfer(1'b0, `GPTP_VAL_A, 32'h0, r);
        chk(32'(r < 32'd20), 32'h1);
        // full width: borrow from first half into second
        wr(`GPTP_CFG, 32'(full_one_shot));
        wr(`GPTP_MODE_A, 32'h0);
        wr(`GPTP_LOAD_A, 32'h3);
        wr(`GPTP_LOAD_B, 32'h1);
        wr(`GPTP_CTL, 32'h1);
        repeat (12) @(posedge hclk);
        rd(`GPTP_VAL_B, 32'h0);
        xfer(1'b0, `GPTP_VAL_A, 32'h0, r);
        chk(32'(r[15]), 32'h1);
        // rtc: 12 slow edges over a divider of 4 give 3 seconds
        wr(`GPTP_CFG, 32'(full_rtc));
        wr(`GPTP_LOAD_A, 32'h0);
        wr(`GPTP_LOAD_B, 32'h0);
        wr(`GPTP_MATCH_A, 32'h2);
        wr(`GPTP_MATCH_B, 32'h0);
        wr(`GPTP_ICLR, 32'h7f);
        wr(`GPTP_CTL, 32'h1);
        repeat (12) begin
            rtc_clk_in <= 1'b1;
            repeat (2) @(posedge hclk);
            rtc_clk_in <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
        rd(`GPTP_VAL_A, 32'h3);
        rd(`GPTP_VAL_B, 32'h0);
        xfer(1'b0, `GPTP_RIS, 32'h0, r);
        chk(32'(r[3]), 32'h1);
        finish_test;
    end
endmodule : general_purpose_timer_pair_tb

/* verification/gptp_pin_model.sv */
// gptp_pin_model: far side of the two capture/pwm pins
// assumes both pins idle high through a pull-up while nobody drives them
`timescale 1ns/1ps
module gptp_pin_model (
    input wire logic hclk,
    input wire logic [1:0] pwm_out,
    input wire logic [1:0] pwm_oe,
    output logic [1:0] cap_in
);
    logic [1:0] drv_ff = 2'b11;
    int high_cnt = 0;
    // ****************
    // pin level
    // ****************
    // design owns the pin while enabled, else our drive or the pull-up
    always_comb cap_in = (pwm_oe & pwm_out) | (~pwm_oe & drv_ff);
    always @(posedge hclk) begin
        if (pwm_oe[1] === 1'b1 && cap_in[1] === 1'b1) high_cnt++;
    end
    // low pulses, 2 cycles a level: one fall then one rise each
    task automatic pulse(input int pin, input int n);
        repeat (n) begin
            drv_ff[pin] <= 1'b0;
            repeat (2) @(posedge hclk);
            drv_ff[pin] <= 1'b1;
            repeat (2) @(posedge hclk);
        end
    endtask : pulse
endmodule : gptp_pin_model
